// file: rtl/flash_sr1_pkg.sv
// Constants for the volatile status register one block
package flash_sr1_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int REG_WRITE_NS  = 200;
  localparam logic [7:0] REG_WRITE_CYC =
    8'((REG_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // Command codes
  localparam logic [7:0] SET_WRITE_ENABLE_CMD    = 8'h06;
  localparam logic [7:0] SET_VOLATILE_ENABLE_CMD = 8'h50;
  localparam logic [7:0] WRITE_DISABLE_CMD       = 8'h04;
  localparam logic [7:0] WRITE_REGS_CMD          = 8'h01;
  localparam logic [7:0] WRITE_ANY_REG_CMD       = 8'h71;
  localparam logic [7:0] READ_STATUS_ONE_CMD     = 8'h05;
  localparam logic [7:0] READ_STATUS_TWO_CMD     = 8'h07;
  localparam logic [7:0] READ_ANY_REG_CMD        = 8'h65;
  localparam logic [7:0] CLEAR_STATUS_CMD        = 8'h30;
  localparam logic [7:0] SUSPEND_CMD             = 8'h75;
  localparam logic [7:0] RESET_ARM_CMD           = 8'h66;
  localparam logic [7:0] RESET_FIRE_CMD          = 8'h99;

  // ==========================================================
  // Register addresses for the any-register commands
  localparam logic [23:0] STATUS_ONE_ADDR = 24'h000010;
  localparam logic [23:0] STATUS_TWO_ADDR = 24'h000011;

  // ==========================================================
  // Field positions
  localparam int LOCK_POS      = 7;
  localparam int GRAN_POS      = 6;
  localparam int ORIGIN_POS    = 5;
  localparam int RANGE_LSB     = 2;
  localparam int RANGE_MSB     = 4;
  localparam int LATCH_POS     = 1;
  localparam int BUSY_POS      = 0;
  localparam int ERASE_ERR_POS = 6;
  localparam int PROG_ERR_POS  = 5;

  // ==========================================================
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [3:0] PIN_RST    = 4'h5;

  // ==========================================================
  // Frame states, Gray coded along the path through F_ADDR
  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_CMD  = 2'b01,
    F_ADDR = 2'b11,
    F_DATA = 2'b10
  } frame_t;

endpackage

// file: rtl/pin_sync.sv
// Two-stage synchroniser, one stage pair per bit
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  // ==========================================================
  // Per-bit flop pair; the first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge i_clock or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          meta_q <= RST_VAL[g];
          sync_q <= RST_VAL[g];
        end
        else
        begin
          meta_q <= i_async[g];
          sync_q <= meta_q;
        end
      end
      assign o_sync[g] = sync_q;
    end
  endgenerate

endmodule
`default_nettype wire

// file: rtl/flash_status_reg1.sv
// Volatile status register one with command handling
`timescale 1ns/100ps
`default_nettype none
module flash_status_reg1 (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // Serial link pins
  input  wire logic       i_sck,
  input  wire logic       i_cs_n,
  input  wire logic       i_si,
  input  wire logic       i_wp_n,
  output logic            o_so,
  output logic            o_so_oe,
  // Non-volatile defaults
  input  wire logic       i_lock_default,
  input  wire logic       i_granularity_default,
  input  wire logic       i_origin_default,
  input  wire logic [2:0] i_range_default,
  input  wire logic       i_latch_factory_default,
  input  wire logic       i_busy_default,
  // Quad mode enables
  input  wire logic       i_quad_command_mode,
  input  wire logic       i_quad_io_mode,
  // Array engine
  input  wire logic       i_array_req,
  input  wire logic       i_array_done,
  input  wire logic       i_erase_fail,
  input  wire logic       i_program_fail,
  output logic            o_array_start,
  output logic            o_suspend,
  output logic            o_soft_reset,
  // Status
  output logic      [7:0] o_status,
  output logic            o_erase_error,
  output logic            o_program_error,
  output logic            o_regs_locked
);

  // ==========================================================
  // Reset release
  logic rst_m_q;
  logic rst_n_q;
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // ==========================================================
  // Pin sampling and edge finding
  logic [3:0] pins_s;
  logic       sck_p_q;
  logic       cs_p_q;
  pin_sync #(.W(4), .RST_VAL(flash_sr1_pkg::PIN_RST)) u_sync (
    .i_clock (i_clock),
    .i_rst_n (rst_n_q),
    .i_async ({i_sck, i_cs_n, i_si, i_wp_n}),
    .o_sync  (pins_s)
  );
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sck_p_q <= 1'b0;
      cs_p_q  <= 1'b1;
    end
    else
    begin
      sck_p_q <= pins_s[3];
      cs_p_q  <= pins_s[2];
    end
  end

  // Edge and byte decode
  wire        sck_s     = pins_s[3];
  wire        cs_s      = pins_s[2];
  wire        si_s      = pins_s[1];
  wire        wp_s      = pins_s[0];
  wire        in_frame  = ~cs_s;
  wire        sck_rise  = sck_s & ~sck_p_q & in_frame;
  wire        sck_fall  = ~sck_s & sck_p_q & in_frame;
  wire        frame_beg = ~cs_s & cs_p_q;
  wire        end_w     = cs_s & ~cs_p_q;
  logic [5:0] bit_cnt_q;
  logic [7:0] shift_q;
  wire  [7:0] new_byte  = {shift_q[6:0], si_s};
  wire        byte_done = sck_rise & (bit_cnt_q[2:0] == 3'h7);
  wire  [2:0] byte_idx  = bit_cnt_q[5:3];

  // Bit counter saturates so long reads never wrap
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      bit_cnt_q <= 6'h00;
    else if (frame_beg)
      bit_cnt_q <= 6'h00;
    else if (sck_rise && bit_cnt_q != 6'h3F)
      bit_cnt_q <= bit_cnt_q + 6'h01;
  end

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      shift_q <= 8'h00;
    else if (sck_rise)
      shift_q <= new_byte;
  end

  // ==========================================================
  // Frame state machine
  flash_sr1_pkg::frame_t st_q;
  flash_sr1_pkg::frame_t st_d;
  wire has_addr = (new_byte == flash_sr1_pkg::READ_ANY_REG_CMD) |
                  (new_byte == flash_sr1_pkg::WRITE_ANY_REG_CMD);
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      flash_sr1_pkg::F_IDLE:
        if (frame_beg)
          st_d = flash_sr1_pkg::F_CMD;
      flash_sr1_pkg::F_CMD:
        if (byte_done)
          st_d = has_addr ? flash_sr1_pkg::F_ADDR
                          : flash_sr1_pkg::F_DATA;
      flash_sr1_pkg::F_ADDR:
        if (byte_done && byte_idx == 3'h3)
          st_d = flash_sr1_pkg::F_DATA;
      flash_sr1_pkg::F_DATA:
        st_d = flash_sr1_pkg::F_DATA;
      default:
        st_d = flash_sr1_pkg::F_IDLE;
    endcase
    if (end_w)
      st_d = flash_sr1_pkg::F_IDLE;
  end

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      st_q <= flash_sr1_pkg::F_IDLE;
    else
      st_q <= st_d;
  end

  // Opcode, address and first data byte of the frame
  logic [7:0]  opcode_q;
  logic        op_ok_q;
  logic [23:0] addr_q;
  logic [7:0]  data_q;
  logic        data_ok_q;
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      opcode_q  <= 8'h00;
      op_ok_q   <= 1'b0;
      addr_q    <= 24'h000000;
      data_q    <= 8'h00;
      data_ok_q <= 1'b0;
    end
    else if (frame_beg)
    begin
      op_ok_q   <= 1'b0;
      data_ok_q <= 1'b0;
    end
    else if (byte_done)
    begin
      if (st_q == flash_sr1_pkg::F_CMD)
      begin
        opcode_q <= new_byte;
        op_ok_q  <= 1'b1;
      end
      if (st_q == flash_sr1_pkg::F_ADDR)
        addr_q <= {addr_q[15:0], new_byte};
      if (st_q == flash_sr1_pkg::F_DATA && !data_ok_q)
      begin
        data_q    <= new_byte;
        data_ok_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Command decode at frame end
  logic       lock_q, gran_q, origin_q, latch_q, busy_q;
  logic [2:0] range_q;
  logic       locked_q, arm_q, array_q, init_q;
  logic       eerr_q, perr_q;
  logic [7:0] wcnt_q;
  wire op_we   = op_ok_q & (opcode_q == flash_sr1_pkg::SET_WRITE_ENABLE_CMD);
  wire op_wev  = op_ok_q &
                 (opcode_q == flash_sr1_pkg::SET_VOLATILE_ENABLE_CMD);
  wire op_wd   = op_ok_q & (opcode_q == flash_sr1_pkg::WRITE_DISABLE_CMD);
  wire op_wrr  = op_ok_q & (opcode_q == flash_sr1_pkg::WRITE_REGS_CMD);
  wire op_wra  = op_ok_q & (opcode_q == flash_sr1_pkg::WRITE_ANY_REG_CMD);
  wire op_rd1  = op_ok_q & (opcode_q == flash_sr1_pkg::READ_STATUS_ONE_CMD);
  wire op_rd2  = op_ok_q & (opcode_q == flash_sr1_pkg::READ_STATUS_TWO_CMD);
  wire op_rda  = op_ok_q & (opcode_q == flash_sr1_pkg::READ_ANY_REG_CMD);
  wire op_clr  = op_ok_q & (opcode_q == flash_sr1_pkg::CLEAR_STATUS_CMD);
  wire op_sus  = op_ok_q & (opcode_q == flash_sr1_pkg::SUSPEND_CMD);
  wire op_arm  = op_ok_q & (opcode_q == flash_sr1_pkg::RESET_ARM_CMD);
  wire op_rst  = op_ok_q & (opcode_q == flash_sr1_pkg::RESET_FIRE_CMD);
  wire hit1    = addr_q == flash_sr1_pkg::STATUS_ONE_ADDR;
  wire hit2    = addr_q == flash_sr1_pkg::STATUS_TWO_ADDR;
  wire err_any = eerr_q | perr_q;
  // Only the short list gets past a busy device
  wire busy_ok = ~busy_q | op_rd1 | op_rd2 | op_rda | op_sus | op_clr |
                 op_arm | op_rst;
  wire go        = end_w & busy_ok;
  wire set_we_go = go & (op_we | op_wev);
  wire clr_we_go = go & op_wd;
  wire clear_status_cmd_go   = go & op_clr;
  // Writes that only touch this register; other targets ignored
  wire wr_hit    = data_ok_q & (op_wrr | (op_wra & hit1));
  wire wr_go     = go & wr_hit & latch_q & ~busy_q & ~locked_q;
  wire sreset_go = go & op_rst & arm_q;
  wire susp_go   = go & op_sus & array_q;
  wire arr_go    = i_array_req & latch_q & ~busy_q;
  wire fail_now  = i_erase_fail | i_program_fail;
  wire arr_ok    = i_array_done & array_q & ~fail_now & ~err_any;
  wire wr_done   = wcnt_q == 8'h01;
  wire load_w    = ~init_q | sreset_go;
  logic lock_def_q, org_def_q;
  wire lock_chg  = i_lock_default != lock_def_q;
  wire org_chg   = i_origin_default != org_def_q;
  // Quad modes reuse the protect pin as a data line
  wire wp_int    = wp_s | i_quad_command_mode | i_quad_io_mode;

  // Defaults are sampled after release, never under the reset itself
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      init_q     <= 1'b0;
      lock_def_q <= 1'b0;
      org_def_q  <= 1'b0;
      locked_q   <= 1'b0;
      arm_q      <= 1'b0;
    end
    else
    begin
      init_q     <= 1'b1;
      lock_def_q <= i_lock_default;
      org_def_q  <= i_origin_default;
      locked_q   <= lock_q & ~wp_int;
      if (load_w || go)
        arm_q <= ~load_w & op_arm;
    end
  end

  // ==========================================================
  // Protection fields; default tracking wins over a write
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      lock_q   <= 1'b0;
      gran_q   <= 1'b0;
      origin_q <= 1'b0;
      range_q  <= 3'h0;
    end
    else if (load_w)
    begin
      lock_q   <= i_lock_default;
      gran_q   <= i_granularity_default;
      origin_q <= i_origin_default;
      range_q  <= i_range_default;
    end
    else
    begin
      if (wr_go)
      begin
        lock_q   <= data_q[flash_sr1_pkg::LOCK_POS];
        gran_q   <= data_q[flash_sr1_pkg::GRAN_POS];
        origin_q <= data_q[flash_sr1_pkg::ORIGIN_POS];
        range_q  <= data_q[flash_sr1_pkg::RANGE_MSB:flash_sr1_pkg::RANGE_LSB];
      end
      if (lock_chg)
        lock_q <= i_lock_default;
      if (org_chg)
        origin_q <= i_origin_default;
    end
  end

  // ==========================================================
  // Latch, busy, register-write timer, array activity
  // Write data bits 1:0 are dropped; the write itself sets busy until its timer ends
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      latch_q <= 1'b0;
      busy_q  <= 1'b0;
      wcnt_q  <= 8'h00;
      array_q <= 1'b0;
    end
    else if (load_w)
    begin
      latch_q <= i_latch_factory_default;
      busy_q  <= i_busy_default;
      wcnt_q  <= 8'h00;
      array_q <= 1'b0;
    end
    else
    begin
      if (set_we_go)
        latch_q <= 1'b1;
      else if (clr_we_go || clear_status_cmd_go || wr_done || arr_ok)
        latch_q <= 1'b0;
      if (wr_go || arr_go)
        busy_q <= 1'b1;
      else if (wr_done || arr_ok || (clear_status_cmd_go && err_any))
        busy_q <= 1'b0;
      if (wr_go)
        wcnt_q <= flash_sr1_pkg::REG_WRITE_CYC;
      else if (wcnt_q != 8'h00)
        wcnt_q <= wcnt_q - 8'h01;
      if (arr_go)
        array_q <= 1'b1;
      else if (i_array_done || fail_now)
        array_q <= 1'b0;
    end
  end

  // Error flags: a failure in the clearing cycle still lands
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      eerr_q <= 1'b0;
      perr_q <= 1'b0;
    end
    else
    begin
      eerr_q <= (i_erase_fail & array_q) | (eerr_q & ~(clear_status_cmd_go | load_w));
      perr_q <= (i_program_fail & array_q) | (perr_q & ~(clear_status_cmd_go | load_w));
    end
  end

  // ==========================================================
  // Read path: byte loaded on the falling edge opening each byte
  logic [7:0] status_w;
  logic [7:0] two_w;
  logic [7:0] osh_q;
  logic       so_q, oe_q;
  always_comb
  begin
    status_w = flash_sr1_pkg::STATUS_RST;
    status_w[flash_sr1_pkg::LOCK_POS]   = lock_q;
    status_w[flash_sr1_pkg::GRAN_POS]   = gran_q;
    status_w[flash_sr1_pkg::ORIGIN_POS] = origin_q;
    status_w[flash_sr1_pkg::RANGE_MSB:flash_sr1_pkg::RANGE_LSB] = range_q;
    status_w[flash_sr1_pkg::LATCH_POS]  = latch_q;
    status_w[flash_sr1_pkg::BUSY_POS]   = busy_q;
    two_w = flash_sr1_pkg::STATUS_RST;
    two_w[flash_sr1_pkg::ERASE_ERR_POS] = eerr_q;
    two_w[flash_sr1_pkg::PROG_ERR_POS]  = perr_q;
  end
  wire [7:0] rd_sel = (op_rd1 | (op_rda & hit1)) ? status_w :
                      (op_rd2 | (op_rda & hit2)) ? two_w : 8'h00;
  wire       rd_act = (st_q == flash_sr1_pkg::F_DATA) &
                      (op_rd1 | op_rd2 | op_rda);
  wire       ld_w   = sck_fall & rd_act & (bit_cnt_q[2:0] == 3'h0);
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      osh_q <= 8'h00;
      so_q  <= 1'b0;
      oe_q  <= 1'b0;
    end
    else
    begin
      oe_q <= rd_act & in_frame;
      if (ld_w)
      begin
        so_q  <= rd_sel[7];
        osh_q <= {rd_sel[6:0], 1'b0};
      end
      else if (sck_fall && rd_act)
      begin
        so_q  <= osh_q[7];
        osh_q <= {osh_q[6:0], 1'b0};
      end
    end
  end

  // Event pulses to the array engine
  logic start_q, susp_q, srst_q;
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      start_q <= 1'b0;
      susp_q  <= 1'b0;
      srst_q  <= 1'b0;
    end
    else
    begin
      start_q <= arr_go;
      susp_q  <= susp_go;
      srst_q  <= sreset_go;
    end
  end

  // Outputs
  assign o_so            = so_q;
  assign o_so_oe         = oe_q;
  assign o_array_start   = start_q;
  assign o_suspend       = susp_q;
  assign o_soft_reset    = srst_q;
  assign o_status        = status_w;
  assign o_erase_error   = eerr_q;
  assign o_program_error = perr_q;
  assign o_regs_locked   = locked_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n_q);

  lock_block_a: assert property ((end_w && locked_q && !load_w &&
    !lock_chg && !org_chg) |=> $stable(status_w[7:2]))
    else $error("locked register changed");
  write_take_a: assert property ((wr_go && !load_w && !org_chg) |=>
    origin_q == $past(data_q[flash_sr1_pkg::ORIGIN_POS]) &&
    wcnt_q == flash_sr1_pkg::REG_WRITE_CYC)
    else $error("accepted write not applied");
  wp_quad_a: assert property ((i_quad_io_mode ||
    i_quad_command_mode) |=> !locked_q)
    else $error("quad mode left lock active");
  latch_set_a: assert property ((set_we_go && !load_w) |=> latch_q)
    else $error("latch not set");
  keep_bits_a: assert property ((wr_go && !load_w) |=>
    latch_q && busy_q[*8])
    else $error("write changed latch or busy");
  busy_gate_a: assert property ((busy_q && end_w && op_wd &&
    !wr_done && !arr_ok && !load_w) |=> latch_q == $past(latch_q))
    else $error("command taken while busy");
  err_hold_a: assert property ((err_any && !clear_status_cmd_go &&
    !load_w) |=> busy_q)
    else $error("busy dropped with error");
  clear_err_a: assert property ((clear_status_cmd_go && !fail_now) |=>
    !eerr_q && !perr_q && !latch_q)
    else $error("clear status failed");
  suspend_a: assert property (o_suspend |-> $past(array_q))
    else $error("suspend outside array op");
  track_a: assert property ((lock_chg && !load_w) |=>
    lock_q == $past(i_lock_default))
    else $error("lock not tracking default");
  load_a: assert property (load_w |=>
    latch_q == $past(i_latch_factory_default))
    else $error("latch default not loaded");

  wr_c: cover property (wr_go ##[1:60] !busy_q);
  fail_c: cover property (eerr_q ##[1:200] clear_status_cmd_go);
  srst_c: cover property (sreset_go);
  susp_c: cover property (susp_go);

endmodule
`default_nettype wire

// file: tb/spi_host_model.sv
// Host serial controller model that issues command frames
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  // Clock
  input  wire logic i_clock,
  // Serial pins
  input  wire logic i_so,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si
);
  // ==========================================================
  // Frame engine, mode 0, clock parked low outside frames
  initial
  begin
    o_sck  = 1'h0;
    o_cs_n = 1'h1;
    o_si   = 1'h0;
  end

  // Every pin change lands just after a clock edge
  task automatic hc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  // Sends n bytes MSB first from the top of b; rd keeps the last byte
  task automatic frame(input logic [39:0] b, input int n,
                       output logic [7:0] rd);
    rd     = 8'h00;
    o_cs_n = 1'h0;
    hc(10);
    for (int i = 0; i < 8 * n; i++)
    begin
      o_si  = b[39 - i];
      hc(10);
      o_sck = 1'h1;
      rd    = {rd[6:0], i_so};
      hc(10);
      o_sck = 1'h0;
    end
    hc(10);
    o_cs_n = 1'h1;
    // Released line shows no stale bit, it has no pull resistor
    o_si   = ~o_si;
    // Gap of ten clocks keeps frames apart by more than three
    hc(10);
  endtask
endmodule
`default_nettype wire

// file: tb/flash_status_reg1_tb.sv
// Self-checking bench for the volatile status register one block
`timescale 1ns/100ps
`default_nettype none
module flash_status_reg1_tb;
  // ==========================================================
  // Signals
  logic       clock, rst_n, sck, cs_n, si, wp_n, so, lock_d, origin_d;
  logic       qcm, quad_io_mode, req, done, efail, pfail, start, susp, srst;
  logic       eerr, perr, locked, oe, oe_p, gran_d, latch_d, busy_d;
  logic [2:0] range_d;
  int         n_oe = 0;
  logic [7:0] status, rd;
  int         mismatches = 0;
  int         comparisons = 0;
  int         n_st = 0;
  int         n_su = 0;
  int         n_rs = 0;

  // ==========================================================
  // Design, host model and clock
  flash_status_reg1 flash_status_reg1_i (
    .i_clock(clock), .i_rst_n(rst_n), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .i_wp_n(wp_n), .o_so(so), .o_so_oe(oe),
    .i_lock_default(lock_d), .i_granularity_default(gran_d),
    .i_origin_default(origin_d), .i_range_default(range_d),
    .i_latch_factory_default(latch_d), .i_busy_default(busy_d),
    .i_quad_command_mode(qcm), .i_quad_io_mode(quad_io_mode),
    .i_array_req(req), .i_array_done(done), .i_erase_fail(efail),
    .i_program_fail(pfail), .o_array_start(start), .o_suspend(susp),
    .o_soft_reset(srst), .o_status(status), .o_erase_error(eerr),
    .o_program_error(perr), .o_regs_locked(locked));
  spi_host_model spi_host_model_i (.i_clock(clock), .i_so(so),
    .o_sck(sck), .o_cs_n(cs_n), .o_si(si));
  initial
  begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  // Strobes last one clock, so they are counted rather than sampled
  always @(posedge clock)
  begin
    n_st += int'(start === 1'h1);
    n_su += int'(susp === 1'h1);
    n_rs += int'(srst === 1'h1);
    // One rise of the output enable per read frame
    n_oe += int'(oe === 1'h1 && oe_p !== 1'h1);
    oe_p = oe;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [7:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op);
    spi_host_model_i.frame({op, 32'h0}, 1, rd);
  endtask
  task automatic wr(input logic [7:0] d);
    cmd(flash_sr1_pkg::SET_WRITE_ENABLE_CMD);
    spi_host_model_i.frame({flash_sr1_pkg::WRITE_REGS_CMD, d, 24'h0}, 2, rd);
  endtask
  task automatic rd_sr();
    spi_host_model_i.frame({flash_sr1_pkg::READ_STATUS_ONE_CMD, 32'h0}, 2,
                           rd);
  endtask
  // Engine strobes {req, done, erase fail, program fail} for one clock
  task automatic eng(input logic [3:0] v);
    {req, done, efail, pfail} = v;
    spi_host_model_i.hc(1);
    {req, done, efail, pfail} = 4'h0;
    spi_host_model_i.hc(3);
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 300 && status[0] !== 1'h0; k++)
      spi_host_model_i.hc(1);
    if (k == 300)
    begin
      mismatches++;
      finish_test();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {rst_n, lock_d, origin_d, qcm, quad_io_mode} = 5'h00;
    {wp_n, req, done, efail, pfail} = 5'h10;
    {gran_d, range_d, latch_d, busy_d} = 6'h36;
    spi_host_model_i.hc(12);
    rst_n = 1'h1;
    spi_host_model_i.hc(8);
    // Defaults: lock 0, sectors, top, range 5, latch 1, idle
    chk("status", 8'h56, status);
    rd_sr();
    chk("read", 8'h56, rd);
    chk("oe rises", 8'h01, 8'(n_oe));
    chk("oe", 8'h00, {7'h00, oe});
    cmd(flash_sr1_pkg::WRITE_DISABLE_CMD);
    chk("status", 8'h54, status);
    spi_host_model_i.frame({8'h01, 32'h0}, 2, rd);
    chk("status", 8'h54, status);
    cmd(flash_sr1_pkg::SET_VOLATILE_ENABLE_CMD);
    chk("status", 8'h56, status);
    // Low two data bits must not reach latch or busy
    wr(8'hE9);
    chk("busy", 8'h01, {7'h00, status[0]});
    wait_idle();
    chk("status", 8'hE8, status);
    wp_n = 1'h0;
    wr(8'h00);
    chk("locked", 8'h01, {7'h00, locked});
    chk("status", 8'hEA, status);
    qcm = 1'h1;
    spi_host_model_i.hc(4);
    chk("locked", 8'h00, {7'h00, locked});
    {qcm, quad_io_mode} = 2'h1;
    wr(8'h04);
    wait_idle();
    chk("status", 8'h04, status);
    quad_io_mode = 1'h0;
    {lock_d, origin_d} = 2'h3;
    spi_host_model_i.hc(4);
    chk("status", 8'hA4, status);
    {lock_d, origin_d} = 2'h0;
    spi_host_model_i.hc(4);
    chk("status", 8'h04, status);
    wr(8'h1C);
    wait_idle();
    chk("status", 8'h1C, status);
    // Array traffic with the protect pin still low
    cmd(flash_sr1_pkg::SUSPEND_CMD);
    eng(4'h8);
    chk("counts", 8'h00, 8'(n_su + n_st));
    cmd(flash_sr1_pkg::SET_WRITE_ENABLE_CMD);
    eng(4'h8);
    chk("starts", 8'h01, 8'(n_st));
    rd_sr();
    chk("read", 8'h1F, rd);
    cmd(flash_sr1_pkg::WRITE_DISABLE_CMD);
    cmd(flash_sr1_pkg::SUSPEND_CMD);
    chk("suspends", 8'h01, 8'(n_su));
    eng(4'h7);
    chk("errors", 8'h03, {6'h00, eerr, perr});
    chk("status", 8'h1F, status);
    cmd(flash_sr1_pkg::CLEAR_STATUS_CMD);
    chk("errors", 8'h00, {6'h00, eerr, perr});
    chk("status", 8'h1C, status);
    cmd(flash_sr1_pkg::SET_WRITE_ENABLE_CMD);
    eng(4'h8);
    eng(4'h4);
    chk("status", 8'h1C, status);
    cmd(flash_sr1_pkg::RESET_ARM_CMD);
    cmd(flash_sr1_pkg::RESET_FIRE_CMD);
    chk("resets", 8'h01, 8'(n_rs));
    chk("status", 8'h56, status);
    // Other defaults, busy one: write enable is refused, the reset pair gets back in
    {gran_d, range_d, latch_d, busy_d} = 6'h09;
    cmd(flash_sr1_pkg::RESET_ARM_CMD);
    cmd(flash_sr1_pkg::RESET_FIRE_CMD);
    chk("status", 8'h09, status);
    busy_d = 1'h0;
    cmd(flash_sr1_pkg::SET_WRITE_ENABLE_CMD);
    chk("status", 8'h09, status);
    cmd(flash_sr1_pkg::RESET_ARM_CMD);
    cmd(flash_sr1_pkg::RESET_FIRE_CMD);
    chk("resets", 8'h03, 8'(n_rs));
    chk("status", 8'h08, status);
    chk("oe rises", 8'h02, 8'(n_oe));
    finish_test();
  end
endmodule
`default_nettype wire
